/* uetc_ctrl.sv */
// Endpoint transaction controller for function endpoints 0 to 2.
// Assumes a serial engine that decodes tokens and packets and reports
// host handshakes; the microcontroller reaches registers on a byte bus.
// Overview of operation
// [R01] SETUP with eight bytes: store, ACK, flag
// [R02] No-data status: DATA1 zero length, then done
// [R03] Control read IN: NAK unless buffer loaded
// [R04] Retry until ACK, clear loaded, set done
// [R05] Read status OUT: NAK while done set
// [R06] SETUP reception clears data-stage-end bit
// [R07] Control write OUT: store, ACK, flag
// [R08] Write status IN: DATA1 zero length, then done
// [R09] Interrupt/bulk IN endpoint: NAK, send, retry
// [R10] Interrupt/bulk OUT endpoint: store, ACK, flag
// [R11] Acknowledge bit clears endpoint interrupt source
// [R12] Unreadable bits read zero, unwritable ignored
// [R13] New hub address used after enable bit
// [R14] Address registers reset to zero
// [R15] Single-address bit shares one address
// [R16] Hub address field is seven bits
// [R17] Function enable gates function endpoint traffic
// [R18] Single-address mode ignores function enable
// [R19] Firmware programs address after status phase
// [R20] No-data setup: firmware sets end, stall
// [R21] Control read: firmware fills, then loads
// [R22] OUT flag set: NAK, keep FIFO
// [R23] Each endpoint owns an 8-byte FIFO
// [R24] Forced stall answers unexpected tokens with STALL
`timescale 1ns/100ps
module uetc_ctrl
  import uetc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [12:0] i_cpu_addr,
  input  wire logic        i_cpu_wr,
  input  wire logic        i_cpu_rd,
  input  wire logic [7:0]  i_cpu_wdata,
  output logic      [7:0]  o_cpu_rdata,
  input  wire logic        i_tok_valid,
  input  wire logic [1:0]  i_tok_pid,
  input  wire logic [6:0]  i_tok_addr,
  input  wire logic [1:0]  i_tok_ep,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_end,
  input  wire logic        i_host_ack,
  input  wire logic        i_tx_next,
  output logic             o_hs_valid,
  output logic      [1:0]  o_hs_code,
  output logic             o_tx_start,
  output logic             o_tx_data1,
  output logic      [3:0]  o_tx_len,
  output logic      [7:0]  o_tx_data,
  output logic             o_irq
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [1:0] ep_of(input logic [12:0] a, input logic [12:0] base);
    logic [12:0] d;
    d = base - a;
    ep_of = (a <= base && d < 13'h0003) ? d[1:0] : NO_EP;
  endfunction : ep_of

  function automatic logic [4:0] fidx(input logic [1:0] ep, input logic [2:0] p);
    fidx = {ep, p};
  endfunction : fidx

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] hub_addr, fn_addr, global_state;
  logic [6:0] act_hub;
  logic [7:0] ep_ctrl [0:2];
  logic [2:0] rx_out, tx_compl, tx_ready, data_end, irq_src;
  logic       setup_flag, force_stall;
  logic [7:0] mem [0:23];
  logic [3:0] cnt [0:2];
  logic [2:0] cpu_ptr [0:2];
  uetc_ph_t   phase;
  uetc_act_t  cur_act;
  logic [1:0] cur_ep;
  logic       cur_setup, pend_zlp;
  logic [3:0] rx_ptr;
  logic [2:0] tx_ptr;

  logic [1:0] ctrl_sel, stat_sel, cack_sel, data_sel, cnt_sel;
  assign ctrl_sel = ep_of(i_cpu_addr, A_EP_CTRL0);
  assign stat_sel = ep_of(i_cpu_addr, A_EP_STAT0);
  assign cack_sel = ep_of(i_cpu_addr, A_EP_CACK0);
  assign data_sel = ep_of(i_cpu_addr, A_EP_DATA0);
  assign cnt_sel  = ep_of(i_cpu_addr, A_EP_CNT0);

  // ****************************************************************
  // Token decode
  // ****************************************************************
  logic       single, addr_ok, hit, ep_dir;
  logic [1:0] tep;
  assign single  = hub_addr[SA_BIT];                                 // [R15]
  assign addr_ok = single ? (i_tok_addr == act_hub)                  // [R15]
                 : (i_tok_addr == fn_addr[6:0]) && fn_addr[FN_ON_BIT]; // [R17] [R18]
  assign tep     = i_tok_ep;
  assign hit     = i_tok_valid && addr_ok && tep != NO_EP && ep_ctrl[tep][CT_ON];
  assign ep_dir  = (tep != NO_EP) && ep_ctrl[tep][CT_DIR];

  logic      is_setup, is_in, is_out, in_data, in_zlp, ev_rx, ev_ack;
  uetc_act_t tok_act;
  assign is_setup = hit && i_tok_pid == TOK_SETUP && tep == 2'h0;
  assign is_in    = hit && i_tok_pid == TOK_IN;
  assign is_out   = hit && i_tok_pid == TOK_OUT;
  always_comb begin
    tok_act = ACT_NAK;
    in_data = 1'b0;
    in_zlp  = 1'b0;
    if (is_setup) begin
      tok_act = ACT_STORE;                                           // [R01]
    end else if (is_out) begin
      if (tep == 2'h0 && ep_dir) begin
        tok_act = (tx_compl[0] || rx_out[0]) ? ACT_NAK : ACT_STATUS; // [R05] [R22]
      end else if (ep_dir || rx_out[tep]) begin
        tok_act = ACT_NAK;                                           // [R22]
      end else if (tep == 2'h0 && data_end[0] && force_stall) begin
        tok_act = ACT_STALL;                                         // [R24]
      end else begin
        tok_act = ACT_STORE;                                         // [R07] [R10]
      end
    end else if (is_in) begin
      if (tep == 2'h0 && data_end[0] && !ep_dir) begin
        in_zlp = 1'b1;                                               // [R02] [R08]
      end else if (ep_dir && !(tep == 2'h0 && data_end[0])) begin
        in_data = tx_ready[tep];                                     // [R03] [R09]
      end else if (tep == 2'h0 && force_stall) begin
        tok_act = ACT_STALL;                                         // [R24]
      end
    end
  end
  assign ev_rx  = phase == PH_RX && i_rx_end && !i_tok_valid;
  assign ev_ack = phase == PH_WAIT && i_host_ack && !i_tok_valid;

  // ****************************************************************
  // Transaction sequencing
  // ****************************************************************
  // A new token while waiting for the host ACK means the ACK was lost,
  // so the pending packet stays loaded and is simply sent again.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase     <= PH_IDLE;
      cur_act   <= ACT_NAK;
      cur_ep    <= 2'h0;
      cur_setup <= 1'b0;
      pend_zlp  <= 1'b0;
    end else if (hit) begin
      cur_ep    <= tep;
      cur_act   <= tok_act;
      cur_setup <= is_setup;
      pend_zlp  <= in_zlp;
      if (is_in) begin
        phase <= (in_data || in_zlp) ? PH_WAIT : PH_IDLE;            // [R04] [R09]
      end else begin
        phase <= PH_RX;
      end
    end else if (i_tok_valid || ev_rx || ev_ack) begin
      phase <= PH_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hs_valid <= 1'b0;
      o_hs_code  <= HS_NAK;
      o_tx_start <= 1'b0;
      o_tx_data1 <= 1'b0;
      o_tx_len   <= 4'h0;
    end else begin
      o_hs_valid <= 1'b0;
      o_tx_start <= 1'b0;
      if (is_in && (in_data || in_zlp)) begin
        o_tx_start <= 1'b1;
        o_tx_data1 <= in_zlp | ep_ctrl[tep][CT_TGL];
        o_tx_len   <= in_zlp ? 4'h0 : cnt[tep];
      end else if (is_in) begin
        o_hs_valid <= 1'b1;
        o_hs_code  <= (tok_act == ACT_STALL) ? HS_STALL : HS_NAK;    // [R03] [R24]
      end else if (ev_rx) begin
        o_hs_valid <= 1'b1;
        unique case (cur_act)
          ACT_STORE, ACT_STATUS: o_hs_code <= HS_ACK;                // [R01] [R07]
          ACT_STALL:             o_hs_code <= HS_STALL;
          ACT_NAK:               o_hs_code <= HS_NAK;                // [R22]
        endcase
      end
    end
  end

  // ****************************************************************
  // FIFO storage and transmit path
  // ****************************************************************
  logic ack_data;
  assign ack_data = ev_ack && !pend_zlp;
  always_ff @(posedge i_clk) begin
    if (hit) begin
      rx_ptr <= 4'h0;
    end else if (phase == PH_RX && cur_act == ACT_STORE && i_rx_valid && rx_ptr < FIFO_LEN) begin
      mem[fidx(cur_ep, rx_ptr[2:0])] <= i_rx_data;                   // [R23]
      rx_ptr <= rx_ptr + 4'h1;
    end else if (i_cpu_wr && data_sel != NO_EP) begin
      mem[fidx(data_sel, cpu_ptr[data_sel])] <= i_cpu_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_ptr    <= 3'h0;
      o_tx_data <= RESET_BYTE;
    end else if (is_in && in_data) begin
      o_tx_data <= mem[fidx(tep, 3'h0)];
      tx_ptr    <= 3'h1;
    end else if (i_tx_next) begin
      o_tx_data <= mem[fidx(cur_ep, tx_ptr)];
      tx_ptr    <= tx_ptr + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int e = 0; e < 3; e++) begin
      if (i_reset) begin
        cnt[e]     <= 4'h0;
        cpu_ptr[e] <= 3'h0;
      end else if (ev_rx && cur_act == ACT_STORE && cur_ep == e[1:0]) begin
        cnt[e]     <= cur_setup ? SETUP_LEN : rx_ptr;                // [R01]
        cpu_ptr[e] <= 3'h0;
      end else if (i_cpu_wr && cnt_sel == e[1:0]) begin
        cnt[e]     <= (i_cpu_wdata[3:0] > FIFO_LEN) ? FIFO_LEN : i_cpu_wdata[3:0];
        cpu_ptr[e] <= 3'h0;
      end else if ((i_cpu_wr || i_cpu_rd) && data_sel == e[1:0]) begin
        cpu_ptr[e] <= cpu_ptr[e] + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Endpoint flags
  // ****************************************************************
  // Hardware sets are applied after software clears so that an event in
  // the same cycle as its acknowledge is never lost.
  logic [2:0] set_rxo, set_txc, clr_rxo, clr_txc, clr_rdy;
  logic       set_setup;
  always_comb begin
    set_rxo   = 3'h0;
    set_txc   = 3'h0;
    clr_rxo   = 3'h0;
    clr_txc   = 3'h0;
    clr_rdy   = 3'h0;
    set_setup = ev_rx && cur_setup;
    if (ev_rx && !cur_setup && (cur_act == ACT_STORE || cur_act == ACT_STATUS)) begin
      set_rxo[cur_ep] = 1'b1;                                        // [R05] [R07] [R10]
    end
    if (ev_ack) begin
      set_txc[cur_ep] = 1'b1;                                        // [R02] [R04] [R08]
      clr_rdy[cur_ep] = !pend_zlp;                                   // [R04] [R09]
    end
    if (i_cpu_wr && cack_sel != NO_EP) begin
      clr_rxo[cack_sel] = i_cpu_wdata[CA_RXO_ACK];
      clr_txc[cack_sel] = i_cpu_wdata[CA_TXC_ACK];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_out     <= 3'h0;
      tx_compl   <= 3'h0;
      setup_flag <= 1'b0;
    end else if (set_setup) begin
      rx_out     <= {rx_out[2:1], 1'b0};
      tx_compl   <= {tx_compl[2:1], 1'b0};
      setup_flag <= 1'b1;                                            // [R01]
    end else begin
      rx_out   <= (rx_out & ~clr_rxo) | set_rxo;
      tx_compl <= (tx_compl & ~clr_txc) | set_txc;
      if (i_cpu_wr && cack_sel == 2'h0 && i_cpu_wdata[CA_SET_ACK]) begin
        setup_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_ready    <= 3'h0;
      data_end    <= 3'h0;
      force_stall <= 1'b0;
    end else begin
      // A register write to one endpoint must not mask a completion on another.
      tx_ready <= tx_ready & ~clr_rdy;                               // [R04] [R09]
      if (i_cpu_wr && cack_sel != NO_EP) begin
        tx_ready[cack_sel] <= i_cpu_wdata[CA_TXRDY] & ~clr_rdy[cack_sel];
        data_end[cack_sel] <= i_cpu_wdata[CA_DEND];
        if (cack_sel == 2'h0) begin
          force_stall <= i_cpu_wdata[CA_STALL];
        end
      end
      if (set_setup) begin
        data_end[0] <= 1'b0;                                         // [R06]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_src <= 3'h0;
    end else begin
      for (int e = 0; e < 3; e++) begin
        if (set_rxo[e] || set_txc[e] || (e == 0 && set_setup)) begin
          irq_src[e] <= 1'b1;
        end else if (i_cpu_wr && i_cpu_addr == A_IRQ_ACK && i_cpu_wdata[e]) begin
          irq_src[e] <= 1'b0;                                        // [R11]
        end
      end
    end
  end
  assign o_irq = |irq_src;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hub_addr     <= RESET_BYTE;                                    // [R14]
      fn_addr      <= RESET_BYTE;                                    // [R14]
      global_state <= RESET_BYTE;
      act_hub      <= 7'h00;
    end else if (i_cpu_wr) begin
      if (i_cpu_addr == A_HUB_ADDR) begin
        hub_addr <= i_cpu_wdata;                                     // [R16]
      end
      if (i_cpu_addr == A_FN_ADDR) begin
        fn_addr <= i_cpu_wdata;                                      // [R17]
      end
      if (i_cpu_addr == A_GLOBAL) begin
        global_state <= {7'h00, i_cpu_wdata[ADD_EN_BIT]};
        if (i_cpu_wdata[ADD_EN_BIT]) begin
          act_hub <= hub_addr[6:0];                                  // [R13]
        end
      end
    end
  end

  // Hardware toggles the data toggle bit after each stored OUT packet and each acknowledged IN data packet; SETUP sets it.
  always_ff @(posedge i_clk) begin
    for (int e = 0; e < 3; e++) begin
      if (i_reset) begin
        ep_ctrl[e] <= RESET_BYTE;
      end else if (i_cpu_wr && ctrl_sel == e[1:0]) begin
        ep_ctrl[e] <= {i_cpu_wdata[7], 3'h0, i_cpu_wdata[3:0]};      // [R12]
      end else if (set_setup && e == 0) begin
        ep_ctrl[e][CT_TGL] <= 1'b1;
      end else if ((ack_data || (ev_rx && cur_act == ACT_STORE && !cur_setup))
                   && cur_ep == e[1:0]) begin
        ep_ctrl[e][CT_TGL] <= ~ep_ctrl[e][CT_TGL];
      end
    end
  end

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cpu_rdata <= RESET_BYTE;
    end else if (i_cpu_rd) begin
      o_cpu_rdata <= RESET_BYTE;                                     // [R12]
      if (i_cpu_addr == A_HUB_ADDR) o_cpu_rdata <= hub_addr;
      if (i_cpu_addr == A_FN_ADDR) o_cpu_rdata <= fn_addr;
      if (i_cpu_addr == A_GLOBAL) o_cpu_rdata <= global_state;
      if (i_cpu_addr == A_IRQ_STAT) o_cpu_rdata <= {5'h00, irq_src};
      if (ctrl_sel != NO_EP) o_cpu_rdata <= ep_ctrl[ctrl_sel];
      if (stat_sel != NO_EP) o_cpu_rdata <= {5'h00, stat_sel == 2'h0 && setup_flag,
                                             rx_out[stat_sel], tx_compl[stat_sel]};
      if (cack_sel != NO_EP) o_cpu_rdata <= {1'b0, cack_sel == 2'h0 && force_stall,
                                             data_end[cack_sel], tx_ready[cack_sel], 4'h0};
      if (data_sel != NO_EP) o_cpu_rdata <= mem[fidx(data_sel, cpu_ptr[data_sel])];
      if (cnt_sel != NO_EP) o_cpu_rdata <= {4'h0, cnt[cnt_sel]};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence setup_done_s;
    phase == PH_RX && cur_setup && i_rx_end && !i_tok_valid;
  endsequence
  sequence ack_sent_s;
    o_hs_valid && o_hs_code == HS_ACK;
  endsequence
  sequence out_blocked_s;
    is_out && rx_out[tep];
  endsequence

  setup_ack_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R01]
    setup_done_s |=> ack_sent_s and setup_flag && cnt[0] == SETUP_LEN)
    else $error("setup not acknowledged");
  setup_dend_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R06]
    setup_done_s |=> !data_end[0] ##1 1'b1)
    else $error("setup left data end set");
  read_nak_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R03]
    is_in && tep == 2'h0 && ep_dir && !data_end[0] && !tx_ready[0]
    |=> o_hs_valid && o_hs_code == HS_NAK && !o_tx_start)
    else $error("control read without NAK");
  status_zlp_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R02]
    is_in && tep == 2'h0 && data_end[0] && !ep_dir
    |=> o_tx_start && o_tx_len == 4'h0 && o_tx_data1)
    else $error("status stage packet wrong");
  tx_done_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R04]
    ack_data && !(i_cpu_wr && cack_sel == cur_ep)
    |=> !tx_ready[$past(cur_ep)] && tx_compl[$past(cur_ep)] && o_irq)
    else $error("transmit completion missed");
  out_nak_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R22]
    out_blocked_s |=> phase == PH_RX && cur_act == ACT_NAK)
    else $error("OUT accepted while flag set");
  out_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R22]
    ev_rx && cur_act == ACT_NAK && !i_cpu_wr
    |=> o_hs_valid && o_hs_code == HS_NAK && $stable(cnt[cur_ep]))
    else $error("refused OUT changed endpoint state");
  hub_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
    act_hub != $past(act_hub)
    |-> $past(i_cpu_wr && i_cpu_addr == A_GLOBAL && i_cpu_wdata[ADD_EN_BIT]))
    else $error("hub address switched early");
  irq_clear_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    i_cpu_wr && i_cpu_addr == A_IRQ_ACK && i_cpu_wdata[1] && !set_rxo[1] && !set_txc[1]
    |=> !irq_src[1])
    else $error("interrupt source not cleared");
  fn_gate_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R17]
    i_tok_valid && !single && !fn_addr[FN_ON_BIT] |-> !hit)
    else $error("disabled function answered");
endmodule : uetc_ctrl

/* uetc_host_model.sv */
// Host-side model: issues tokens and data packets and consumes sent bytes.
// Assumes the bench commands each transaction and judges the answers.
`timescale 1ns/100ps
module uetc_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_tx_start,
  input  wire logic [3:0] i_tx_len,
  output logic            o_tok_valid,
  output logic [1:0]      o_tok_pid,
  output logic [6:0]      o_tok_addr,
  output logic [1:0]      o_tok_ep,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end,
  output logic            o_host_ack,
  output logic            o_tx_next
);
  logic [3:0] left = 4'h0;
  initial begin
    {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep} = '0;
    {o_rx_valid, o_rx_data, o_rx_end, o_host_ack, o_tx_next} = '0;
  end
  // Pulls one byte a cycle, the fastest a serial engine could ever ask.
  always @(posedge i_clk) begin
    #1;
    o_tx_next = (left != 4'h0);
    left = i_tx_start ? i_tx_len : left - {3'h0, o_tx_next};
  end
  task automatic token(input logic [1:0] pid, input logic [6:0] addr, input logic [1:0] ep);
    {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep} = {1'b1, pid, addr, ep};
    @(posedge i_clk);
    #1;
    o_tok_valid = 1'b0;
    o_tok_addr = ~addr;
  endtask : token
  // Released data lines show the inverse of the last byte; a zero-length packet re-inverts them to a stale copy.
  task automatic packet(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      {o_rx_valid, o_rx_data} = {1'b1, base + 8'(i)};
      @(posedge i_clk);
      #1;
    end
    {o_rx_valid, o_rx_data, o_rx_end} = {1'b0, ~o_rx_data, 1'b1};
    @(posedge i_clk);
    #1;
    o_rx_end = 1'b0;
  endtask : packet
  task automatic ack();
    o_host_ack = 1'b1;
    @(posedge i_clk);
    #1;
    o_host_ack = 1'b0;
  endtask : ack
endmodule : uetc_host_model

/* uetc_pkg.sv */
// Constants and types for the USB endpoint transaction controller.
// Assumes an 8-bit microcontroller bus with 13-bit byte addresses.
package uetc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [12:0] A_HUB_ADDR  = 13'h1FEF;
  localparam logic [12:0] A_FN_ADDR   = 13'h1FEE;
  localparam logic [12:0] A_GLOBAL    = 13'h1FED;
  localparam logic [12:0] A_IRQ_STAT  = 13'h1FE9;
  localparam logic [12:0] A_IRQ_ACK   = 13'h1FE8;
  localparam logic [12:0] A_EP_CTRL0  = 13'h1FE5;
  localparam logic [12:0] A_EP_STAT0  = 13'h1FDF;
  localparam logic [12:0] A_EP_CACK0  = 13'h1FDB;
  localparam logic [12:0] A_EP_DATA0  = 13'h1FD5;
  localparam logic [12:0] A_EP_CNT0   = 13'h1FCD;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SA_BIT     = 7;
  localparam int FN_ON_BIT  = 7;
  localparam int ADD_EN_BIT = 0;
  localparam int CT_ON      = 7;
  localparam int CT_TGL     = 3;
  localparam int CT_DIR     = 2;
  localparam int ST_SETUP   = 2;
  localparam int ST_RXOUT   = 1;
  localparam int ST_TXC     = 0;
  localparam int CA_RXO_ACK = 0;
  localparam int CA_TXC_ACK = 1;
  localparam int CA_SET_ACK = 2;
  localparam int CA_TXRDY   = 4;
  localparam int CA_DEND    = 5;
  localparam int CA_STALL   = 6;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INT  = 2'h3;
  localparam logic [1:0] NO_EP     = 2'h3;
  localparam logic [3:0] FIFO_LEN  = 4'h8;
  localparam logic [3:0] SETUP_LEN = 4'h8;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h3} uetc_tok_t;
  typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h3} uetc_hs_t;
  typedef enum logic [1:0] {ACT_NAK = 2'h0, ACT_STALL = 2'h1,
                            ACT_STORE = 2'h2, ACT_STATUS = 2'h3} uetc_act_t;
  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_RX = 2'h1, PH_WAIT = 2'h3} uetc_ph_t;
endpackage : uetc_pkg

/* usb_endpoint_transaction_ctrl_bench.sv */
// Self-checking bench for the endpoint transaction controller.
// Assumes the host model above stands on the token side.
`timescale 1ns/100ps
module usb_endpoint_transaction_ctrl_bench;
  import uetc_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_cpu_wr = 1'b0, i_cpu_rd = 1'b0;
  logic [12:0] i_cpu_addr = '0;
  logic [7:0]  i_cpu_wdata = '0, o_cpu_rdata, o_tx_data, i_rx_data;
  logic        i_tok_valid, i_rx_valid, i_rx_end, i_host_ack, i_tx_next;
  logic [1:0]  i_tok_pid, i_tok_ep, o_hs_code;
  logic [6:0]  i_tok_addr;
  logic        o_hs_valid, o_tx_start, o_tx_data1, o_irq;
  logic [3:0]  o_tx_len;
  int          error_cnt = 0, checked = 0;
  logic [7:0]  tx_first;
  logic [4:0]  tx_head;
  always #5 i_clk = ~i_clk;
  uetc_ctrl dut (.i_clk(i_clk), .i_reset(i_reset), .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr),
    .i_cpu_rd(i_cpu_rd), .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata),
    .i_tok_valid(i_tok_valid), .i_tok_pid(i_tok_pid), .i_tok_addr(i_tok_addr),
    .i_tok_ep(i_tok_ep), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_end(i_rx_end),
    .i_host_ack(i_host_ack), .i_tx_next(i_tx_next), .o_hs_valid(o_hs_valid),
    .o_hs_code(o_hs_code), .o_tx_start(o_tx_start), .o_tx_data1(o_tx_data1),
    .o_tx_len(o_tx_len), .o_tx_data(o_tx_data), .o_irq(o_irq));
  uetc_host_model host (.i_clk(i_clk), .i_tx_start(o_tx_start), .i_tx_len(o_tx_len),
    .o_tok_valid(i_tok_valid), .o_tok_pid(i_tok_pid), .o_tok_addr(i_tok_addr),
    .o_tok_ep(i_tok_ep), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_end(i_rx_end),
    .o_host_ack(i_host_ack), .o_tx_next(i_tx_next));
  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic summarize();
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    {i_cpu_wr, i_cpu_addr, i_cpu_wdata} = {1'b1, a, d};
    @(posedge i_clk);
    #1;
    i_cpu_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp, input logic [7:0] m);
    {i_cpu_rd, i_cpu_addr} = {1'b1, a};
    @(posedge i_clk);
    #1;
    i_cpu_rd = 1'b0;
    chk($sformatf("reg %h", a), exp & m, o_cpu_rdata & m);
  endtask : rd_chk
  // Answer codes: 0 ACK, 1 NAK, 3 STALL, 10 data packet, FF nothing.
  task automatic resp_chk(input logic [7:0] exp);
    logic [7:0] got;
    got = 8'hFF;
    for (int i = 0; i < 12 && got === 8'hFF; i++) begin
      if (o_hs_valid === 1'b1) got = {6'h0, o_hs_code};
      else if (o_tx_start === 1'b1) got = 8'h10;
      else begin
        @(posedge i_clk);
        #1;
      end
    end
    {tx_head, tx_first} = {o_tx_data1, o_tx_len, o_tx_data};
    chk("answer", exp, got);
  endtask : resp_chk
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    rd_chk(A_HUB_ADDR, 8'h00, 8'hFF);
    rd_chk(A_FN_ADDR, 8'h00, 8'hFF);
    rd_chk(13'h1000, 8'h00, 8'hFF);
    wr(A_FN_ADDR, 8'h8A);
    wr(A_EP_CTRL0, 8'h80);
    wr(A_HUB_ADDR, 8'h05);
    rd_chk(A_HUB_ADDR, 8'h05, 8'hFF);
    host.token(TOK_SETUP, 7'h0A, 2'h0);
    host.packet(8, 8'h40);
    resp_chk(8'h00);
    chk("irq", 8'h01, {7'h0, o_irq});
    rd_chk(A_EP_STAT0, 8'h04, 8'hFF);
    rd_chk(A_EP_DATA0, 8'h40, 8'hFF);
    rd_chk(A_IRQ_STAT, 8'h01, 8'hFF);
    wr(A_IRQ_ACK, 8'h03);
    rd_chk(A_IRQ_STAT, 8'h00, 8'hFF);
    wr(A_EP_CACK0, 8'h04);
    wr(A_EP_CTRL0, 8'h8C);
    host.token(TOK_IN, 7'h0A, 2'h0);
    resp_chk(8'h01);
    wr(A_EP_CNT0, 8'h02);
    wr(A_EP_DATA0, 8'h11);
    wr(A_EP_DATA0, 8'h22);
    wr(A_EP_CACK0, 8'h10);
    host.token(TOK_IN, 7'h0A, 2'h0);
    resp_chk(8'h10);
    chk("head", 8'h12, {3'h0, tx_head});
    chk("byte0", 8'h11, tx_first);
    repeat (2) @(posedge i_clk);
    #1;
    chk("byte1", 8'h22, o_tx_data);
    host.ack();
    rd_chk(A_EP_CACK0, 8'h00, 8'h10);
    rd_chk(A_EP_STAT0, 8'h01, 8'hFF);
    host.token(TOK_OUT, 7'h0A, 2'h0);
    host.packet(0, 8'h00);
    resp_chk(8'h01);
    wr(A_EP_CACK0, 8'h02);
    host.token(TOK_OUT, 7'h0A, 2'h0);
    host.packet(0, 8'h00);
    resp_chk(8'h00);
    rd_chk(A_EP_STAT0, 8'h02, 8'hFF);
    host.token(TOK_OUT, 7'h0A, 2'h0);
    host.packet(2, 8'h77);
    resp_chk(8'h01);
    wr(A_EP_CNT0, 8'h02);
    rd_chk(A_EP_DATA0, 8'h11, 8'hFF);
    host.token(TOK_IN, 7'h0B, 2'h0);
    resp_chk(8'hFF);
    wr(A_FN_ADDR, 8'h0A);
    host.token(TOK_IN, 7'h0A, 2'h0);
    resp_chk(8'hFF);
    wr(A_HUB_ADDR, 8'h85);
    host.token(TOK_IN, 7'h05, 2'h0);
    resp_chk(8'hFF);
    wr(A_GLOBAL, 8'h01);
    host.token(TOK_IN, 7'h05, 2'h0);
    resp_chk(8'h01);
    wr(A_EP_CACK0, 8'h60);
    host.token(TOK_IN, 7'h05, 2'h0);
    resp_chk(8'h03);
    host.token(TOK_SETUP, 7'h05, 2'h0);
    host.packet(8, 8'h50);
    resp_chk(8'h00);
    rd_chk(A_EP_CACK0, 8'h00, 8'h20);
    wr(A_EP_CACK0, 8'h64);
    wr(A_EP_CTRL0, 8'h80);
    host.token(TOK_IN, 7'h05, 2'h0);
    resp_chk(8'h10);
    chk("head", 8'h10, {3'h0, tx_head});
    host.ack();
    rd_chk(A_EP_STAT0, 8'h01, 8'h01);
    wr(A_EP_CTRL0 - 13'h0001, 8'h82);
    host.token(TOK_OUT, 7'h05, 2'h1);
    host.packet(2, 8'h31);
    resp_chk(8'h00);
    rd_chk(A_EP_STAT0 - 13'h0001, 8'h02, 8'hFF);
    rd_chk(A_EP_DATA0 - 13'h0001, 8'h31, 8'hFF);
    host.token(TOK_OUT, 7'h05, 2'h1);
    host.packet(1, 8'h99);
    resp_chk(8'h01);
    rd_chk(A_EP_DATA0 - 13'h0001, 8'h32, 8'hFF);
    summarize();
  end
endmodule : usb_endpoint_transaction_ctrl_bench
